// file: zcd_pkg.sv
// Purpose: constants shared by the crossing detector logic
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes:   offsets are byte addresses
package zcd_pkg;

  localparam int          ZCD_ADDR_WIDTH      = 4;
  localparam int          ZCD_DATA_WIDTH      = 32;

  // register byte offsets
  localparam logic [3:0]  ZCD_OFS_CONTROL     = 4'h0;
  localparam logic [3:0]  ZCD_OFS_FLAG        = 4'h4;
  localparam logic [3:0]  ZCD_OFS_ENABLE      = 4'h8;
  localparam logic [3:0]  ZCD_OFS_IRQ_CTRL    = 4'hc;

  // crossing_control_reg fields
  localparam int          ZCD_BIT_MODULE_EN   = 7;
  localparam int          ZCD_BIT_STATE       = 5;
  localparam int          ZCD_BIT_INVERT      = 4;
  localparam int          ZCD_BIT_RISE_EN     = 1;
  localparam int          ZCD_BIT_FALL_EN     = 0;

  // peripheral_flag_reg_three / peripheral_enable_reg_three field
  localparam int          ZCD_BIT_CROSSING    = 0;

  // irq_control_reg fields
  localparam int          ZCD_BIT_GLOBAL      = 7;
  localparam int          ZCD_BIT_PERIPH      = 6;

  localparam logic        ZCD_RESET_BIT       = 1'b0;
  localparam int          ZCD_SYNC_STAGES     = 2;

endpackage

// file: zcd_logic.sv
// Purpose: digital side of a zero-cross detector behind an apb slave
// Assumes: sink_active comes straight from the analogue comparator, asynchronous
// Notes:   single clock pclk, asynchronous active-low reset presetn
//
// Functional notes
// - status bit shows whether the current source or sink is active
// - invert clear: state high while sink active, low while source active
// - invert set: state high while source active, low while sink active
// - edge detection acts on the state after polarity inversion
// - separate rising and falling edge detectors on the crossing state
// - flag sets when a detector fires and its own enable is set
// - rise enable qualifies rising edges, fall enable falling edges
// - interrupt out only with flag enable, peripheral and global gates set
// - changing the inversion control raises an event even when disabled
// - an edge in the clearing cycle wins; the flag stays set
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module zcd_logic
  import zcd_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ZCD_ADDR_WIDTH-1:0] paddr,
  input  wire logic [ZCD_DATA_WIDTH-1:0] pwdata,
  output logic      [ZCD_DATA_WIDTH-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      sink_active,
  output logic                           crossing_state,
  output logic                           irq
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic                       module_enable;
  logic                       output_invert;
  logic                       rise_irq_enable;
  logic                       fall_irq_enable;
  logic                       crossing_irq_flag;
  logic                       crossing_irq_enable;
  logic                       peripheral_irq_gate;
  logic                       global_irq_gate;
  logic [ZCD_SYNC_STAGES-1:0] sink_sync;
  logic                       state_prev;
  logic                       next_state;
  logic                       rise_seen;
  logic                       fall_seen;
  logic                       invert_change;
  logic                       access;
  logic                       wr_control;
  logic                       wr_flag;
  logic                       known_addr;
  logic [ZCD_DATA_WIDTH-1:0]  next_prdata;

  // decode one register select at the access phase
  function automatic logic zcd_hit(input logic [ZCD_ADDR_WIDTH-1:0] a,
                                   input logic [ZCD_ADDR_WIDTH-1:0] ofs);
    return a == ofs;
  endfunction

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // no wait states: every access completes in its first access cycle
  assign access     = psel && penable && pready;
  assign wr_control = access && pwrite && zcd_hit(paddr, ZCD_OFS_CONTROL);
  assign wr_flag    = access && pwrite && zcd_hit(paddr, ZCD_OFS_FLAG);
  assign known_addr = zcd_hit(paddr, ZCD_OFS_CONTROL) || zcd_hit(paddr, ZCD_OFS_FLAG) ||
                      zcd_hit(paddr, ZCD_OFS_ENABLE) || zcd_hit(paddr, ZCD_OFS_IRQ_CTRL);

  // ---------------------------------------------------------------
  // input synchroniser and polarity
  // ---------------------------------------------------------------
  // two-stage sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_sync <= '0;
    end else begin
      sink_sync <= {sink_sync[ZCD_SYNC_STAGES-2:0], sink_active};
    end
  end

  assign next_state = sink_sync[ZCD_SYNC_STAGES-1] ^ output_invert;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crossing_state <= ZCD_RESET_BIT;
    end else begin
      crossing_state <= next_state;
    end
  end

  // detectors after inversion
  // the detectors compare the registered state with its previous value, so an
  // inversion write flips the state and is seen as an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_prev <= ZCD_RESET_BIT;
    end else begin
      state_prev <= crossing_state;
    end
  end

  assign rise_seen = crossing_state && !state_prev;
  assign fall_seen = !crossing_state && state_prev;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_enable   <= ZCD_RESET_BIT;
      output_invert   <= ZCD_RESET_BIT;
      rise_irq_enable <= ZCD_RESET_BIT;
      fall_irq_enable <= ZCD_RESET_BIT;
    end else if (wr_control) begin
      module_enable   <= pwdata[ZCD_BIT_MODULE_EN];
      output_invert   <= pwdata[ZCD_BIT_INVERT];
      rise_irq_enable <= pwdata[ZCD_BIT_RISE_EN];
      fall_irq_enable <= pwdata[ZCD_BIT_FALL_EN];
    end
  end

  // inversion change event
  // raised independently of module_enable; kept as a one-cycle pulse so a
  // change is flagged even when the synchronised input happens to toggle too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      invert_change <= ZCD_RESET_BIT;
    end else begin
      invert_change <= wr_control && (pwdata[ZCD_BIT_INVERT] != output_invert);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crossing_irq_enable <= ZCD_RESET_BIT;
    end else if (access && pwrite && zcd_hit(paddr, ZCD_OFS_ENABLE)) begin
      crossing_irq_enable <= pwdata[ZCD_BIT_CROSSING];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_gate     <= ZCD_RESET_BIT;
      peripheral_irq_gate <= ZCD_RESET_BIT;
    end else if (access && pwrite && zcd_hit(paddr, ZCD_OFS_IRQ_CTRL)) begin
      global_irq_gate     <= pwdata[ZCD_BIT_GLOBAL];
      peripheral_irq_gate <= pwdata[ZCD_BIT_PERIPH];
    end
  end

  // ---------------------------------------------------------------
  // crossing flag
  // ---------------------------------------------------------------
  // qualified set beats software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crossing_irq_flag <= ZCD_RESET_BIT;
    end else if ((rise_seen && rise_irq_enable) || (fall_seen && fall_irq_enable) ||
                 invert_change) begin
      crossing_irq_flag <= 1'b1;
    end else if (wr_flag) begin
      crossing_irq_flag <= pwdata[ZCD_BIT_CROSSING];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= ZCD_RESET_BIT;
    end else begin
      irq <= crossing_irq_flag && crossing_irq_enable &&
             peripheral_irq_gate && global_irq_gate;
    end
  end

  // ---------------------------------------------------------------
  // apb read path and response
  // ---------------------------------------------------------------
  always_comb begin
    next_prdata = '0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ZCD_OFS_CONTROL: begin
          next_prdata[ZCD_BIT_MODULE_EN] = module_enable;
          next_prdata[ZCD_BIT_STATE]     = crossing_state;
          next_prdata[ZCD_BIT_INVERT]    = output_invert;
          next_prdata[ZCD_BIT_RISE_EN]   = rise_irq_enable;
          next_prdata[ZCD_BIT_FALL_EN]   = fall_irq_enable;
        end
        ZCD_OFS_FLAG: begin
          next_prdata[ZCD_BIT_CROSSING] = crossing_irq_flag;
        end
        ZCD_OFS_ENABLE: begin
          next_prdata[ZCD_BIT_CROSSING] = crossing_irq_enable;
        end
        ZCD_OFS_IRQ_CTRL: begin
          next_prdata[ZCD_BIT_GLOBAL] = global_irq_gate;
          next_prdata[ZCD_BIT_PERIPH] = peripheral_irq_gate;
        end
        default: begin
          next_prdata = '0;
        end
      endcase
    end
  end

  // data is captured in the setup cycle so prdata is a flop at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !known_addr;
    end
  end

endmodule

// file: zcd_sink_model.sv
// Purpose: model of the analogue sink/source indication
// Assumes: want is the sink level the bench asks for
// Notes:   moves off the clock edge, as a comparator would
`timescale 1ns/10ps
module zcd_sink_model (
  input  wire logic want,
  output logic      sink_active
);
  always @(want) sink_active <= #3 want;
  initial sink_active = 1'b0;
endmodule

// file: zcd_logic_sva.sv
// Purpose: port checks for the crossing detector
// Assumes: helper copies of written bits track the design
// Notes:   bound to every zcd_logic
`timescale 1ns/10ps
module zcd_logic_sva
  import zcd_pkg::*;
(
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [ZCD_ADDR_WIDTH-1:0] paddr,
  input wire logic [ZCD_DATA_WIDTH-1:0] pwdata,
  input wire logic [ZCD_DATA_WIDTH-1:0] prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic                      sink_active,
  input wire logic                      crossing_state,
  input wire logic                      irq
);
  logic [7:0] ctl;
  logic [7:0] gat;
  logic       ie;
  logic [2:0] up;
  logic       wr;
  logic       ga;
  assign wr = psel & penable & pready & pwrite;
  assign ga = ie & gat[ZCD_BIT_GLOBAL] & gat[ZCD_BIT_PERIPH];
  // up masks the sync pipe, still full of reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'h0;
      gat <= 8'h0;
      ie  <= 1'b0;
      up  <= 3'h0;
    end else begin
      if (!up[2]) up <= up + 3'h1;
      if (wr && paddr == ZCD_OFS_CONTROL) ctl <= pwdata[7:0];
      if (wr && paddr == ZCD_OFS_ENABLE) ie <= pwdata[ZCD_BIT_CROSSING];
      if (wr && paddr == ZCD_OFS_IRQ_CTRL) gat <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_map: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00))
    else $error("pslverr wrong for address");
  chk_state_map: assert property (
    up[2] |-> crossing_state == ($past(sink_active, 3) ^ $past(ctl[ZCD_BIT_INVERT])))
    else $error("crossing state wrong");
  chk_rise_flag: assert property (
    $rose(crossing_state) && ctl[ZCD_BIT_RISE_EN] && ga |=> ##1 irq)
    else $error("rising edge lost");
  chk_fall_flag: assert property (
    $fell(crossing_state) && ctl[ZCD_BIT_FALL_EN] && ga |=> ##1 irq)
    else $error("falling edge lost");
  chk_irq_gated: assert property (irq |-> $past(ga))
    else $error("irq without all enables");
  chk_inv_event: assert property (
    wr && paddr == ZCD_OFS_CONTROL && pwdata[ZCD_BIT_INVERT] != ctl[ZCD_BIT_INVERT]
    && ga |-> ##[3:4] irq)
    else $error("invert change gave no event");
  chk_flag_held: assert property ($fell(irq) |-> $past(wr, 2))
    else $error("irq dropped without a write");
endmodule
bind zcd_logic zcd_logic_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sink_active(sink_active),
  .crossing_state(crossing_state), .irq(irq));

// file: zcd_logic_tb_top.sv
// Purpose: self-checking bench for the crossing detector
// Assumes: apb master moves only right after rising edges
// Notes:   one flag clear per round is timed onto a fresh edge
`timescale 1ns/10ps
module zcd_logic_tb_top import zcd_pkg::*; ;
  logic        pclk, presetn, psel, penable, pwrite, want;
  logic [3:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready, pslverr, sink_active, crossing_state, irq;
  logic        inv, ren, fen, men, ie, gg, pg, flag, s0;
  int          err_total, total_checks, seed;
  logic [31:0] rnd;
  zcd_logic u_zcd_logic (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sink_active(sink_active), .crossing_state(crossing_state), .irq(irq));
  zcd_sink_model u_zcd_sink_model (.want(want), .sink_active(sink_active));
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  function automatic logic [31:0] ctl_word();
    return (32'(men) << ZCD_BIT_MODULE_EN) | (32'(want ^ inv) << ZCD_BIT_STATE)
      | (32'(inv) << ZCD_BIT_INVERT) | (32'(ren) << ZCD_BIT_RISE_EN) | 32'(fen);
  endfunction
  function automatic logic [31:0] expv(input logic [3:0] a);
    case (a)
      ZCD_OFS_CONTROL:  return ctl_word();
      ZCD_OFS_FLAG:     return 32'(flag);
      ZCD_OFS_ENABLE:   return 32'(ie);
      ZCD_OFS_IRQ_CTRL: return (32'(gg) << ZCD_BIT_GLOBAL) | (32'(pg) << ZCD_BIT_PERIPH);
      default:          return 32'h0;
    endcase
  endfunction
  task automatic check_all();
    logic [31:0] r;
    logic        e;
    for (int a = 0; a < 16; a++) begin
      apb(1'b0, a[3:0], 32'h0, r, e);
      chk("prdata", expv(a[3:0]), r);
      chk("pslverr", 32'(a[1:0] != 2'b00), 32'(e));
    end
    chk("state", 32'(want ^ inv), 32'(crossing_state));
    chk("irq", 32'(flag & ie & gg & pg), 32'(irq));
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, want, paddr, pwdata} = 41'h0;
    {inv, ren, fen, men, ie, gg, pg, flag} = 8'h0;
    err_total = 0;
    total_checks = 0;
    seed = 32'h15d0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check_all();
    wr(4'h6, 32'hffffffff);
    check_all();
    for (int i = 0; i < 24; i++) begin
      rnd = $random(seed);
      {pg, gg, ie} = {rnd[6] | rnd[9], rnd[5] | rnd[8], rnd[4]};
      // gates first: chk_inv_event only checks an invert write made while all gates are already set
      wr(ZCD_OFS_IRQ_CTRL, expv(ZCD_OFS_IRQ_CTRL));
      wr(ZCD_OFS_ENABLE, 32'(ie));
      {men, ren, fen} = rnd[2:0];
      if (rnd[3] != inv) flag = 1'b1;
      inv = rnd[3];
      wr(ZCD_OFS_CONTROL, ctl_word());
      repeat (6) @(posedge pclk);
      check_all();
      wr(ZCD_OFS_FLAG, 32'h0);
      flag = 1'b0;
      s0 = want ^ inv;
      @(posedge pclk);
      want <= ~want;
      @(posedge pclk);
      wr(ZCD_OFS_FLAG, 32'h0);
      flag = s0 ? fen : ren;
      repeat (4) @(posedge pclk);
      check_all();
    end
    conclude();
  end
endmodule
